// ### verilog/rpm_ctrl.sv
`timescale 1ns/10ps
module rpm_ctrl #(
  parameter int CRYSTAL_OSCILLATOR_STAB_CYC = rpm_pkg::RPM_CRYSTAL_OSCILLATOR_STAB_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire rpm_pkg::rpm_av_req_t av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata,
  input wire logic external_reset_in_n,
  input wire logic wdt_timeout,
  input wire logic pll_lock,
  input wire logic [rpm_pkg::RPM_GPIO_N-1:0] gpio_wake,
  input wire logic rtc_wake,
  input wire logic usb_wake,
  output logic hard_reset_out,
  output logic system_reset_out,
  output logic system_reset_out_n,
  output logic periph_reset_out,
  output logic sys_clk_en,
  output logic [31:0] bus_clock_en,
  output logic clk_src_pll,
  output logic pll_power_en,
  output logic crystal_en,
  output logic [15:0] pll_div_cfg
);

  // ****************************************
  // Input filters
  // ****************************************
  logic ext_n_flt;
  logic lock_flt;

  rpm_filt #(.CYC(rpm_pkg::RPM_EXT_FILT_CYC), .RST_VAL(1'b1)) u_ext_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(external_reset_in_n),
    .q(ext_n_flt)
  );

  rpm_filt #(.CYC(rpm_pkg::RPM_GLITCH_CYC), .RST_VAL(1'b0)) u_lock_filt (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(pll_lock),
    .q(lock_flt)
  );

  // ****************************************
  // Hard reset
  // ****************************************
  logic hard_rst_r;
  logic [3:0] quiet_r;
  wire ext_act = !ext_n_flt;
  wire hard_src = reset | ext_act | wdt_timeout;

  always_ff @(posedge clk_sys or posedge hard_src) begin
    if (hard_src) begin
      hard_rst_r <= 1'b1;
      quiet_r <= 4'h0;
    end else if (hard_rst_r) begin
      hard_rst_r <= quiet_r != rpm_pkg::RPM_QUIET_LAST;
      quiet_r <= quiet_r + 4'h1;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] pll_r;
  logic [31:0] clk_r;
  logic [31:0] cken_r;
  logic [31:0] cfg_r;
  logic [4:0] cause_r;
  logic [31:0] bmask;
  logic [31:0] rd_mux;

  wire req = av_req.read | av_req.write;
  wire take = av_req.write & !wait_r;
  wire [31:0] wd = av_req.writedata;
  wire wr_pll = take && av_req.address == rpm_pkg::RPM_OFS_PLL;
  wire wr_clk = take && av_req.address == rpm_pkg::RPM_OFS_CLK;
  wire wr_cken = take && av_req.address == rpm_pkg::RPM_OFS_CKEN;
  wire wr_cause = take && av_req.address == rpm_pkg::RPM_OFS_CAUSE;
  wire wr_cfg = take && av_req.address == rpm_pkg::RPM_OFS_CFG;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign bmask[gi*8 +: 8] = {8{av_req.byteenable[gi]}};
    end
  endgenerate

  wire [31:0] wbits = wd & bmask;
  wire [31:0] pll_rd = {pll_r[31:2], lock_flt, pll_r[rpm_pkg::RPM_PLL_EN_BIT]};

  always_comb begin
    if (av_req.address == rpm_pkg::RPM_OFS_PLL) begin
      rd_mux = pll_rd;
    end else if (av_req.address == rpm_pkg::RPM_OFS_CLK) begin
      rd_mux = clk_r;
    end else if (av_req.address == rpm_pkg::RPM_OFS_CKEN) begin
      rd_mux = cken_r;
    end else if (av_req.address == rpm_pkg::RPM_OFS_CAUSE) begin
      rd_mux = {27'h0000000, cause_r};
    end else if (av_req.address == rpm_pkg::RPM_OFS_ID) begin
      rd_mux = rpm_pkg::RPM_ID_VAL;
    end else if (av_req.address == rpm_pkg::RPM_OFS_CFG) begin
      rd_mux = cfg_r;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (hard_rst_r) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= !(req && wait_r);
      if (av_req.read && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ****************************************
  // Soft and peripheral reset
  // ****************************************
  logic [3:0] soft_cnt_r;
  logic [3:0] per_cnt_r;
  wire soft_req = wr_cfg && wbits[rpm_pkg::RPM_CFG_SOFT_BIT];
  wire per_req = wr_cfg && wbits[rpm_pkg::RPM_CFG_PREQ_BIT];
  wire soft_act = soft_req || soft_cnt_r != 4'h0;
  wire per_act = per_req || per_cnt_r != 4'h0;
  wire sys_rst_nxt = hard_rst_r | soft_act;
  wire per_rst_nxt = sys_rst_nxt | per_act;

  always_ff @(posedge clk_sys) begin
    if (hard_rst_r) begin
      soft_cnt_r <= 4'h0;
      per_cnt_r <= 4'h0;
    end else begin
      soft_cnt_r <= soft_req ? rpm_pkg::RPM_SOFT_LAST : soft_cnt_r - {3'h0, soft_cnt_r != 4'h0};
      per_cnt_r <= per_req ? rpm_pkg::RPM_SOFT_LAST : per_cnt_r - {3'h0, per_cnt_r != 4'h0};
    end
  end

  // ****************************************
  // Reset cause log
  // ****************************************
  wire [4:0] cause_set = {per_req, soft_req, wdt_timeout, ext_act, 1'b0};
  wire [4:0] cause_clr = wr_cause ? wbits[4:0] : 5'h00;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cause_r <= rpm_pkg::RPM_CAUSE_RST;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // ****************************************
  // Power mode sequencer
  // ****************************************
  rpm_pkg::rpm_state_t st_r;
  rpm_pkg::rpm_state_t st_nxt;
  logic [15:0] stab_r;
  logic [15:0] stab_nxt;
  logic idle_clr;
  logic xdis_clr;

  wire gpio_hit = |gpio_wake && cfg_r[rpm_pkg::RPM_CFG_GPIO_BIT];
  wire rtc_hit = rtc_wake && cfg_r[rpm_pkg::RPM_CFG_RTC_BIT];
  wire usb_hit = usb_wake && cfg_r[rpm_pkg::RPM_CFG_USB_BIT];
  wire wake_hit = gpio_hit | rtc_hit | usb_hit;
  wire stab_done = stab_r == 16'(CRYSTAL_OSCILLATOR_STAB_CYC - 1);

  always_comb begin
    st_nxt = st_r;
    stab_nxt = 16'h0000;
    idle_clr = 1'b0;
    xdis_clr = 1'b0;
    case (st_r)
      rpm_pkg::RPM_ST_STAB: begin
        stab_nxt = stab_r + 16'h0001;
        if (stab_done) begin
          st_nxt = rpm_pkg::RPM_ST_RUN;
          stab_nxt = 16'h0000;
        end
      end
      rpm_pkg::RPM_ST_RUN: begin
        if (cfg_r[rpm_pkg::RPM_CFG_XDIS_BIT]) begin
          st_nxt = rpm_pkg::RPM_ST_STOP;
        end else if (cfg_r[rpm_pkg::RPM_CFG_IDLE_BIT]) begin
          st_nxt = rpm_pkg::RPM_ST_IDLE;
        end
      end
      rpm_pkg::RPM_ST_IDLE: begin
        if (wake_hit) begin
          st_nxt = rpm_pkg::RPM_ST_RUN;
          idle_clr = 1'b1;
        end
      end
      default: begin
        if (wake_hit) begin
          st_nxt = rpm_pkg::RPM_ST_STAB;
          xdis_clr = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // Power management registers
  // ****************************************
  wire [31:0] pll_nxt = wr_pll ? (pll_r & ~(bmask & rpm_pkg::RPM_PLL_WMASK)) | (wbits & rpm_pkg::RPM_PLL_WMASK)
                               : pll_r;
  wire [31:0] clk_nxt = wr_clk ? (clk_r & ~(bmask & rpm_pkg::RPM_CLK_WMASK)) | (wbits & rpm_pkg::RPM_CLK_WMASK)
                               : clk_r;
  wire [31:0] cken_nxt = wr_cken ? (cken_r & ~bmask) | wbits : cken_r;
  wire [31:0] cfg_wr = wr_cfg ? (cfg_r & ~(bmask & rpm_pkg::RPM_CFG_WMASK)) | (wbits & rpm_pkg::RPM_CFG_WMASK)
                              : cfg_r;
  wire [31:0] cfg_hw_clr = {23'h000000, xdis_clr, 3'h0, idle_clr, 4'h0};
  wire [31:0] cfg_nxt = cfg_wr & ~cfg_hw_clr;

  always_ff @(posedge clk_sys) begin
    if (hard_rst_r) begin
      pll_r <= rpm_pkg::RPM_PLL_RST;
      clk_r <= rpm_pkg::RPM_CLK_RST;
      cken_r <= rpm_pkg::RPM_CKEN_RST;
      cfg_r <= rpm_pkg::RPM_CFG_RST;
      st_r <= rpm_pkg::RPM_ST_STAB;
      stab_r <= 16'h0000;
    end else begin
      pll_r <= pll_nxt;
      clk_r <= clk_nxt;
      cken_r <= cken_nxt;
      cfg_r <= cfg_nxt;
      st_r <= st_nxt;
      stab_r <= stab_nxt;
    end
  end

  // ****************************************
  // Clock and reset outputs
  // ****************************************
  logic sys_rst_r;
  logic sys_rst_n_r;
  logic per_rst_r;
  logic sys_clk_en_r;
  logic [31:0] bus_clk_en_r;
  logic src_pll_r;
  logic pll_en_r;
  logic crystal_oscillator_en_r;

  wire run_nxt = st_nxt == rpm_pkg::RPM_ST_RUN;
  wire stop_nxt = st_nxt == rpm_pkg::RPM_ST_STOP;
  wire pll_on_nxt = pll_nxt[rpm_pkg::RPM_PLL_EN_BIT] && !stop_nxt;
  wire src_nxt = clk_nxt[rpm_pkg::RPM_CLK_SRC_BIT] && lock_flt && pll_on_nxt;

  always_ff @(posedge clk_sys) begin
    if (hard_rst_r) begin
      sys_clk_en_r <= 1'b0;
      bus_clk_en_r <= 32'h0000_0000;
      src_pll_r <= 1'b0;
      pll_en_r <= 1'b0;
      crystal_oscillator_en_r <= 1'b1;
    end else begin
      sys_clk_en_r <= run_nxt;
      bus_clk_en_r <= run_nxt ? cken_nxt : 32'h0000_0000;
      src_pll_r <= src_nxt;
      pll_en_r <= pll_on_nxt;
      crystal_oscillator_en_r <= !stop_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    sys_rst_r <= sys_rst_nxt;
    sys_rst_n_r <= !sys_rst_nxt;
    per_rst_r <= per_rst_nxt;
  end

  assign av_waitrequest = wait_r;
  assign av_readdata = rdata_r;
  assign hard_reset_out = hard_rst_r;
  assign system_reset_out = sys_rst_r;
  assign system_reset_out_n = sys_rst_n_r;
  assign periph_reset_out = per_rst_r;
  assign sys_clk_en = sys_clk_en_r;
  assign bus_clock_en = bus_clk_en_r;
  assign clk_src_pll = src_pll_r;
  assign pll_power_en = pll_en_r;
  assign crystal_en = crystal_oscillator_en_r;
  assign pll_div_cfg = pll_r[31:16];

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] calm_r;

  // Cycles since a hard reset source was last seen, saturating
  always_ff @(posedge clk_sys) begin
    calm_r <= hard_src ? 5'h00 : calm_r + {4'h0, calm_r != 5'h1F};
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence stop_wake_s;
    st_r == rpm_pkg::RPM_ST_STOP && wake_hit;
  endsequence

  sequence restart_s;
    st_r == rpm_pkg::RPM_ST_STAB && !cfg_r[rpm_pkg::RPM_CFG_XDIS_BIT] && crystal_en;
  endsequence

  chk_sys_rst_follow: assert property (hard_rst_r |=> system_reset_out)
    else $error("system reset missed a hard reset");
  chk_rst_pin_level: assert property (system_reset_out_n == !system_reset_out)
    else $error("reset pin level differs from system reset");
  chk_wdt_async: assert property (wdt_timeout |-> hard_rst_r)
    else $error("watchdog did not assert hard reset at once");
  chk_hard_hold: assert property (calm_r <= {1'b0, rpm_pkg::RPM_QUIET_LAST} |-> hard_rst_r)
    else $error("hard reset released before 16 quiet cycles");
  chk_periph_rst: assert property ((system_reset_out || $past(per_req)) |-> periph_reset_out)
    else $error("peripheral reset missing");
  chk_idle_ignore: assert property ((st_r == rpm_pkg::RPM_ST_IDLE && !wake_hit)
    |=> (st_r == rpm_pkg::RPM_ST_IDLE || hard_rst_r))
    else $error("idle ended without a selected wake");
  chk_idle_clocks: assert property (st_r == rpm_pkg::RPM_ST_IDLE |-> bus_clock_en == 32'h0000_0000)
    else $error("module clocks running in idle");
  chk_stop_wake: assert property (stop_wake_s |=> restart_s)
    else $error("stop wake did not restart crystal");
  chk_stab_block: assert property (st_r == rpm_pkg::RPM_ST_STAB |-> !sys_clk_en && bus_clock_en == 32'h0000_0000)
    else $error("clocks released during stabilisation");
  chk_src_lock: assert property (clk_src_pll |-> $past(lock_flt))
    else $error("PLL selected without lock");

endmodule

// ### verilog/rpm_pkg.sv
package rpm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int RPM_CLK_NS = 8;
  localparam int RPM_GLITCH_NS = 20;
  localparam int RPM_GLITCH_CYC = (RPM_GLITCH_NS + RPM_CLK_NS - 1) / RPM_CLK_NS;
  localparam int RPM_EXT_FILT_NS = 40;
  localparam int RPM_EXT_FILT_CYC = (RPM_EXT_FILT_NS + RPM_CLK_NS - 1) / RPM_CLK_NS;
  localparam logic [3:0] RPM_QUIET_LAST = 4'hF;
  localparam logic [3:0] RPM_SOFT_LAST = 4'hF;
  localparam int RPM_CRYSTAL_OSCILLATOR_STAB_CYC = 65536;
  localparam int RPM_GPIO_N = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RPM_OFS_PLL = 8'h00;
  localparam logic [7:0] RPM_OFS_CLK = 8'h04;
  localparam logic [7:0] RPM_OFS_CKEN = 8'h08;
  localparam logic [7:0] RPM_OFS_CAUSE = 8'h0C;
  localparam logic [7:0] RPM_OFS_ID = 8'h14;
  localparam logic [7:0] RPM_OFS_CFG = 8'h1C;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int RPM_PLL_EN_BIT = 0;
  localparam int RPM_PLL_LOCK_BIT = 1;
  localparam logic [31:0] RPM_PLL_RST = 32'h1013_0000;
  localparam logic [31:0] RPM_PLL_WMASK = 32'hFFFF_0001;
  localparam int RPM_CLK_SRC_BIT = 30;
  localparam logic [31:0] RPM_CLK_RST = 32'h0000_0000;
  localparam logic [31:0] RPM_CLK_WMASK = 32'h4101_FF00;
  localparam logic [31:0] RPM_CKEN_RST = 32'hFFFF_FFFF;
  localparam int RPM_CFG_GPIO_BIT = 0;
  localparam int RPM_CFG_RTC_BIT = 1;
  localparam int RPM_CFG_USB_BIT = 2;
  localparam int RPM_CFG_IDLE_BIT = 4;
  localparam int RPM_CFG_XDIS_BIT = 8;
  localparam int RPM_CFG_SOFT_BIT = 16;
  localparam int RPM_CFG_PREQ_BIT = 17;
  localparam logic [31:0] RPM_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] RPM_CFG_WMASK = 32'h0000_0117;
  localparam int RPM_CAUSE_POR = 0;
  localparam int RPM_CAUSE_EXT = 1;
  localparam int RPM_CAUSE_WDT = 2;
  localparam int RPM_CAUSE_SOFT = 3;
  localparam int RPM_CAUSE_PER = 4;
  localparam logic [4:0] RPM_CAUSE_RST = 5'h01;
  // Arbitrary identification value
  localparam logic [31:0] RPM_ID_VAL = 32'h0001_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } rpm_av_req_t;

  typedef enum logic [1:0] {RPM_ST_STAB, RPM_ST_RUN, RPM_ST_IDLE, RPM_ST_STOP} rpm_state_t;

endpackage

// ### verilog/rpm_filt.sv
`timescale 1ns/10ps
// ****************************************
// Level filter: passes a change only after it held CYC cycles
// ****************************************
module rpm_filt #(
  parameter int CYC = 3,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic d,
  output logic q
);
  logic [7:0] cnt_r;
  logic q_r;
  wire differ = d != q_r;
  wire held = cnt_r == 8'(CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_r <= RST_VAL;
      cnt_r <= 8'h00;
    end else if (!differ) begin
      cnt_r <= 8'h00;
    end else if (held) begin
      q_r <= d;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign q = q_r;
endmodule

// ### tb/rpm_far.sv
`timescale 1ns/10ps
// ****************************************
// Far side: PLL lock, one APB and one AHB module
// ****************************************
module rpm_far #(
  parameter int LOCK_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic pll_power_en,
  input wire logic clk_on,
  input wire logic system_reset_out,
  input wire logic periph_reset_out,
  output logic pll_lock,
  output logic [15:0] apb_cnt,
  output logic [15:0] ahb_cnt
);
  int lock_cnt = 0;
  // PLL locks some time after power up, unlocks at once when off
  always_ff @(posedge clk_sys) begin
    lock_cnt <= (pll_power_en === 1'b1) ? lock_cnt + 1 : 0;
  end
  assign pll_lock = (lock_cnt >= LOCK_CYC);
  // APB module cleared by peripheral reset
  always_ff @(posedge clk_sys) begin
    if (periph_reset_out) begin
      apb_cnt <= 16'h0000;
    end else if (clk_on) begin
      apb_cnt <= apb_cnt + 16'h0001;
    end
  end
  // AHB module cleared by system reset only
  always_ff @(posedge clk_sys) begin
    if (system_reset_out) begin
      ahb_cnt <= 16'h0000;
    end else if (clk_on) begin
      ahb_cnt <= ahb_cnt + 16'h0001;
    end
  end
endmodule

// ### tb/reset_and_power_mode_control_tb.sv
`timescale 1ns/10ps
module reset_and_power_mode_control_tb;
  // ****************************************
  // Signals
  // ****************************************
  localparam int STAB = 16;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  rpm_pkg::rpm_av_req_t av_req = '0;
  logic av_waitrequest;
  logic [31:0] av_readdata;
  logic external_reset_in_n = 1'b1;
  logic wdt_timeout = 1'b0;
  logic pll_lock;
  logic [rpm_pkg::RPM_GPIO_N-1:0] gpio_wake = '0;
  logic rtc_wake = 1'b0;
  logic usb_wake = 1'b0;
  logic hard_reset_out, system_reset_out, system_reset_out_n, periph_reset_out, sys_clk_en;
  logic [31:0] bus_clock_en;
  logic clk_src_pll, pll_power_en, crystal_en;
  logic [15:0] pll_div_cfg, apb_cnt, ahb_cnt;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] rng = 32'hC4DF69AC;
  logic [31:0] cken;
  int mismatches = 0;
  int n_checks = 0;
  int n;

  rpm_ctrl #(.CRYSTAL_OSCILLATOR_STAB_CYC(STAB)) dut (.clk_sys(clk_sys), .reset(reset), .av_req(av_req),
    .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .external_reset_in_n(external_reset_in_n),
    .wdt_timeout(wdt_timeout), .pll_lock(pll_lock), .gpio_wake(gpio_wake), .rtc_wake(rtc_wake),
    .usb_wake(usb_wake), .hard_reset_out(hard_reset_out), .system_reset_out(system_reset_out),
    .system_reset_out_n(system_reset_out_n), .periph_reset_out(periph_reset_out), .sys_clk_en(sys_clk_en),
    .bus_clock_en(bus_clock_en), .clk_src_pll(clk_src_pll), .pll_power_en(pll_power_en),
    .crystal_en(crystal_en), .pll_div_cfg(pll_div_cfg));

  rpm_far far (.clk_sys(clk_sys), .pll_power_en(pll_power_en), .clk_on(sys_clk_en & bus_clock_en[0]),
    .system_reset_out(system_reset_out), .periph_reset_out(periph_reset_out), .pll_lock(pll_lock),
    .apb_cnt(apb_cnt), .ahb_cnt(ahb_cnt));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [31:0] m);
    int t = 0;
    @(posedge clk_sys);
    if (!wr) exp_q.push_back({m, d & m});
    av_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk_sys);
      t++;
    end while (av_waitrequest !== 1'b0 && t < 50);
    chk(t < 50, "bus answer missing");
    av_req <= '0;
  endtask

  task automatic wait_run(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (sys_clk_en !== 1'b1 && c < 300);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Read data monitor
  always @(posedge clk_sys) begin
    if (av_req.read && av_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      n_checks++;
      if ((av_readdata & e[63:32]) !== e[31:0]) begin
        mismatches++;
        $display("unexpected at %0t: read %h want %h", $time, av_readdata, e[31:0]);
      end
    end
  end

  initial begin
    #100000;
    mismatches++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    chk(hard_reset_out === 1'b1 && system_reset_out_n === 1'b0, "reset out");
    reset <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (hard_reset_out === 1'b1 && n < 100);
    chk(n == 16, "hard release");
    wait_run(n);
    chk(n >= STAB && n <= STAB + 4 && bus_clock_en === 32'hFFFFFFFF && clk_src_pll === 1'b0, "boot");
    chk(pll_div_cfg === 16'h1013 && crystal_en === 1'b1, "boot pll");
    bus(rpm_pkg::RPM_OFS_PLL, 1'b0, rpm_pkg::RPM_PLL_RST, 32'hFFFFFFFF);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b0, 32'h1, 32'h1F);
    bus(8'h10, 1'b1, rng, 32'h0);
    bus(8'h10, 1'b0, 32'h0, 32'hFFFFFFFF);
    rng = xs(rng);
    cken = rng | 32'h1;
    bus(rpm_pkg::RPM_OFS_CKEN, 1'b1, cken, 32'h0);
    bus(rpm_pkg::RPM_OFS_CKEN, 1'b0, cken, 32'hFFFFFFFF);
    chk(bus_clock_en === cken, "gating");
    bus(rpm_pkg::RPM_OFS_PLL, 1'b1, rpm_pkg::RPM_PLL_RST | 32'h1, 32'h0);
    n = 0;
    while (pll_lock !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (6) @(posedge clk_sys);
    bus(rpm_pkg::RPM_OFS_PLL, 1'b0, rpm_pkg::RPM_PLL_RST | 32'h3, 32'hFFFFFFFF);
    bus(rpm_pkg::RPM_OFS_CLK, 1'b1, 32'h40000000, 32'h0);
    @(posedge clk_sys);
    #1 chk(clk_src_pll === 1'b1 && pll_power_en === 1'b1, "pll source");
    bus(rpm_pkg::RPM_OFS_PLL, 1'b1, rpm_pkg::RPM_PLL_RST, 32'h0);
    repeat (6) @(posedge clk_sys);
    #1 chk(clk_src_pll === 1'b0 && pll_power_en === 1'b0, "crystal fallback");
    for (int k = 0; k < 3; k++) begin
      bus(rpm_pkg::RPM_OFS_CFG, 1'b1, (32'h1 << k) | 32'h10, 32'h0);
      repeat (3) @(posedge clk_sys);
      #1 chk(sys_clk_en === 1'b0 && bus_clock_en === 32'h0 && crystal_en === 1'b1, "idle");
      @(posedge clk_sys);
      rng = xs(rng);
      gpio_wake <= (k != 0) ? (rng[2:0] | 3'h1) : 3'h0;
      rtc_wake <= (k != 1);
      usb_wake <= (k != 2);
      repeat (4) @(posedge clk_sys);
      {gpio_wake, rtc_wake, usb_wake} <= '0;
      repeat (3) @(posedge clk_sys);
      #1 chk(sys_clk_en === 1'b0, "unselected wake");
      @(posedge clk_sys);
      gpio_wake <= (k == 0) ? 3'h4 : 3'h0;
      rtc_wake <= (k == 1);
      usb_wake <= (k == 2);
      @(posedge clk_sys);
      {gpio_wake, rtc_wake, usb_wake} <= '0;
      wait_run(n);
      chk(n <= 4 && bus_clock_en === cken, "idle wake");
      bus(rpm_pkg::RPM_OFS_CFG, 1'b0, 32'h1 << k, 32'h117);
    end
    bus(rpm_pkg::RPM_OFS_CFG, 1'b1, 32'h101, 32'h0);
    repeat (3) @(posedge clk_sys);
    #1 chk(crystal_en === 1'b0 && sys_clk_en === 1'b0, "stop");
    @(posedge clk_sys);
    gpio_wake <= 3'h1;
    @(posedge clk_sys);
    gpio_wake <= 3'h0;
    #1 chk(crystal_en === 1'b1, "crystal restart");
    wait_run(n);
    chk(n >= STAB - 2 && n <= STAB + 4, "stop wake delay");
    bus(rpm_pkg::RPM_OFS_CFG, 1'b0, 32'h1, 32'h117);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b1, 32'h1F, 32'h0);
    bus(rpm_pkg::RPM_OFS_CFG, 1'b1, 32'h10000, 32'h0);
    n = 0;
    while (system_reset_out !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(system_reset_out_n === 1'b0 && hard_reset_out === 1'b0, "soft reset");
    n = 0;
    while (system_reset_out === 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(n >= 15 && n <= 18, "soft width");
    bus(rpm_pkg::RPM_OFS_CKEN, 1'b0, cken, 32'hFFFFFFFF);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b0, 32'h08, 32'h0E);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b1, 32'h1F, 32'h0);
    bus(rpm_pkg::RPM_OFS_CFG, 1'b1, 32'h20000, 32'h0);
    repeat (4) @(posedge clk_sys);
    #1 chk(periph_reset_out === 1'b1 && system_reset_out === 1'b0, "periph reset");
    repeat (20) @(posedge clk_sys);
    #1 chk(periph_reset_out === 1'b0 && ahb_cnt > apb_cnt + 16'h8, "ahb kept");
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b0, 32'h10, 32'h1E);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b1, 32'h1F, 32'h0);
    @(posedge clk_sys);
    external_reset_in_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    external_reset_in_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 chk(hard_reset_out === 1'b0 && system_reset_out === 1'b0, "glitch");
    @(posedge clk_sys);
    external_reset_in_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk(hard_reset_out === 1'b1 && system_reset_out_n === 1'b0, "ext reset");
    @(posedge clk_sys);
    external_reset_in_n <= 1'b1;
    wait_run(n);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b0, 32'h02, 32'h07);
    bus(rpm_pkg::RPM_OFS_CKEN, 1'b0, 32'hFFFFFFFF, 32'hFFFFFFFF);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b1, 32'h1F, 32'h0);
    @(posedge clk_sys);
    wdt_timeout <= 1'b1;
    #2 chk(hard_reset_out === 1'b1, "async hard");
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    wait_run(n);
    bus(rpm_pkg::RPM_OFS_CAUSE, 1'b0, 32'h04, 32'h07);
    bus(rpm_pkg::RPM_OFS_PLL, 1'b0, rpm_pkg::RPM_PLL_RST, 32'hFFFFFFFF);
    repeat (2) @(posedge clk_sys);
    chk(exp_q.size() == 0, "reads left");
    wrap_up();
  end
endmodule
